// ---- design/bwp_seq.sv ----
// Buffer load and buffer to page program sequencer, device side.
// Functional notes
// - Opcode 84h loads buffer one, opcode 87h loads buffer two.
// - 528-byte mode load address: 14 ignored bits, 10 byte index bits.
// - 512-byte mode load address: 15 ignored bits, nine byte index bits.
// - After the address, each byte goes to successive buffer locations from the index.
// - Loading past the last location continues at location zero.
// - Bytes are accepted until chip select rises, which ends the load.
// - Opcodes 83h and 86h program a page from buffer one or two with erase.
// - 528-byte mode program address: two ignored, 12 page bits, ten ignored.
// - 512-byte mode program address: three ignored, 12 page bits, nine ignored.
// - On chip select rise, erase the page to ones, then program it from the buffer.
// - Ready/busy shows busy while any erase or program runs.
// - Any byte failing to erase or program sets the fail flag.
// - Opcodes 88h and 89h program from buffer one or two without erase.
// - Opcodes 82h and 85h load then program, address holds page and start index.
// - Combined command loads with wrap, then erases and programs on chip select rise.
module bwp_seq
   import bwp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   input wire logic page_528,
   input wire logic arr_done,
   input wire logic arr_fail,
   output logic arr_erase,
   output logic arr_prog,
   output logic [PAGE_W-1:0] arr_page,
   output logic [IDX_W-1:0] arr_col,
   output logic [BYTE_W-1:0] arr_data,
   output logic status_ready,
   output logic erase_program_fail_flag,
   output logic link_overrun
);
   bwp_stream_if rx_in();
   bwp_stream_if rx_out();

   logic mode_s1, mode_s2;
   bwp_dec_t dec_state;
   bwp_eng_t en_state;
   logic [1:0] addr_cnt;
   logic [15:0] addr_hi;
   logic [23:0] full_addr;
   logic cmd_load, cmd_prog, cmd_erase, cmd_buf;
   logic [IDX_W-1:0] wr_idx;
   logic [IDX_W-1:0] buf_last;
   logic [PAGE_W-1:0] page_index;
   logic [IDX_W-1:0] buffer_byte_index;
   logic prog_buf;
   logic take;
   logic is_mark;
   logic launch;
   logic byte_end;
   logic step_done;
   logic col_last;
   logic [BYTE_W-1:0] buf_mem [0:(2**MEM_AW)-1];

   // ***************************************************************
   // Byte path
   // ***************************************************************
   bwp_spi_rx u_rx (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n),
      .spi_si(spi_si),
      .tx(rx_in.src),
      .overrun(link_overrun)
   );

   bwp_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .wr(rx_in.snk),
      .rd(rx_out.src)
   );

   // A frame end waits at the FIFO head while the engine is busy, so data behind it backs up.
   assign is_mark = rx_out.data[MARK_BIT];
   assign rx_out.ready = !(is_mark && en_state != EN_IDLE);
   assign take = rx_out.valid && rx_out.ready;

   // ***************************************************************
   // Page size strap
   // ***************************************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         mode_s1 <= 1'b0;
         mode_s2 <= 1'b0;
      end else begin
         mode_s1 <= page_528;
         mode_s2 <= mode_s1;
      end
   end

   assign buf_last = mode_s2 ? BUF_LAST_528 : BUF_LAST_512;
   assign full_addr = {addr_hi, rx_out.data[7:0]};

   always_comb begin
      if (mode_s2) begin
         buffer_byte_index = full_addr[IDX_W-1:0];
      end else begin
         buffer_byte_index = {1'b0, full_addr[IDX_MSB_512:0]};
      end
   end

   always_comb begin
      if (mode_s2) begin
         page_index = addr_hi[PAGE_LSB_528+PAGE_W-1-8:PAGE_LSB_528-8];
      end else begin
         page_index = addr_hi[PAGE_LSB_512+PAGE_W-1-8:PAGE_LSB_512-8];
      end
   end

   // ***************************************************************
   // Command decoder
   // ***************************************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         dec_state <= DS_OPC;
         addr_cnt <= '0;
         addr_hi <= '0;
         cmd_load <= 1'b0;
         cmd_prog <= 1'b0;
         cmd_erase <= 1'b0;
         cmd_buf <= 1'b0;
      end else if (take) begin
         if (is_mark) begin
            dec_state <= DS_OPC;
            addr_cnt <= '0;
         end else begin
            case (dec_state)
               DS_OPC: begin
                  cmd_load <= 1'b0;
                  cmd_prog <= 1'b0;
                  cmd_erase <= 1'b0;
                  cmd_buf <= 1'b0;
                  dec_state <= DS_ADDR;
                  case (rx_out.data[7:0])
                     OPC_LOAD_B1: begin
                        cmd_load <= 1'b1;
                     end
                     OPC_LOAD_B2: begin
                        cmd_load <= 1'b1;
                        cmd_buf <= 1'b1;
                     end
                     OPC_PROG_ERASE_B1: begin
                        cmd_prog <= 1'b1;
                        cmd_erase <= 1'b1;
                     end
                     OPC_PROG_ERASE_B2: begin
                        cmd_prog <= 1'b1;
                        cmd_erase <= 1'b1;
                        cmd_buf <= 1'b1;
                     end
                     OPC_PROG_B1: begin
                        cmd_prog <= 1'b1;
                     end
                     OPC_PROG_B2: begin
                        cmd_prog <= 1'b1;
                        cmd_buf <= 1'b1;
                     end
                     OPC_LOAD_PROG_B1: begin
                        cmd_load <= 1'b1;
                        cmd_prog <= 1'b1;
                        cmd_erase <= 1'b1;
                     end
                     OPC_LOAD_PROG_B2: begin
                        cmd_load <= 1'b1;
                        cmd_prog <= 1'b1;
                        cmd_erase <= 1'b1;
                        cmd_buf <= 1'b1;
                     end
                     default: begin
                        dec_state <= DS_HOLD;
                     end
                  endcase
               end
               DS_ADDR: begin
                  // The first two address bytes hold the page index; the last one only feeds the start index.
                  if (addr_cnt == ADDR_LAST) begin
                     addr_cnt <= ADDR_DONE;
                     dec_state <= cmd_load ? DS_DATA : DS_HOLD;
                  end else begin
                     addr_hi <= full_addr[15:0];
                     addr_cnt <= addr_cnt + 1'b1;
                  end
               end
               DS_DATA: begin
                  dec_state <= DS_DATA;
               end
               default: begin
                  dec_state <= DS_HOLD;
               end
            endcase
         end
      end
   end

   // ***************************************************************
   // Buffer write pointer
   // ***************************************************************
   // The pointer wraps at the last location of the page size in force.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wr_idx <= '0;
      end else if (take && !is_mark && dec_state == DS_ADDR && addr_cnt == ADDR_LAST) begin
         wr_idx <= buffer_byte_index;
      end else if (take && !is_mark && dec_state == DS_DATA && wr_idx == buf_last) begin
         wr_idx <= '0;
      end else if (take && !is_mark && dec_state == DS_DATA) begin
         wr_idx <= wr_idx + 1'b1;
      end
   end

   // ***************************************************************
   // Buffer storage
   // ***************************************************************
   // Both buffers share one array; the buffer number is the top address bit.
   always_ff @(posedge clk_sys) begin
      if (take && !is_mark && dec_state == DS_DATA) begin
         buf_mem[{cmd_buf, wr_idx}] <= rx_out.data[7:0];
      end
   end

   // Only a frame that delivered all three address bytes and ended on a byte boundary starts work.
   assign launch = take && is_mark && rx_out.data[0] && cmd_prog && addr_cnt == ADDR_DONE;

   // ***************************************************************
   // Erase and program engine
   // ***************************************************************
   // A launch only happens while idle, since a frame end is held in the FIFO while busy.
   assign byte_end = (en_state == EN_PWAIT) && arr_done;
   assign step_done = ((en_state == EN_EWAIT) || (en_state == EN_PWAIT)) && arr_done;
   assign col_last = (arr_col == buf_last);

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         en_state <= EN_IDLE;
      end else begin
         case (en_state)
            EN_IDLE: begin
               if (launch) begin
                  en_state <= cmd_erase ? EN_ERASE : EN_PROG;
               end
            end
            EN_ERASE: begin
               en_state <= EN_EWAIT;
            end
            EN_EWAIT: begin
               if (arr_done) begin
                  en_state <= EN_PROG;
               end
            end
            EN_PROG: begin
               en_state <= EN_PWAIT;
            end
            EN_PWAIT: begin
               if (arr_done && col_last) begin
                  en_state <= EN_IDLE;
               end else if (arr_done) begin
                  en_state <= EN_PROG;
               end
            end
            default: begin
               en_state <= EN_IDLE;
            end
         endcase
      end
   end

   // ***************************************************************
   // Array port
   // ***************************************************************
   // Requests are single-cycle pulses; the array answers each with one done pulse.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         arr_erase <= 1'b0;
         arr_prog <= 1'b0;
      end else begin
         arr_erase <= (en_state == EN_ERASE);
         arr_prog <= (en_state == EN_PROG);
      end
   end

   // The page stands for the whole operation, so a queued frame cannot disturb it.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         arr_page <= '0;
         prog_buf <= 1'b0;
      end else if (launch) begin
         arr_page <= page_index;
         prog_buf <= cmd_buf;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         arr_col <= '0;
      end else if (launch) begin
         arr_col <= '0;
      end else if (byte_end && !col_last) begin
         arr_col <= arr_col + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         arr_data <= '0;
      end else if (en_state == EN_PROG) begin
         arr_data <= buf_mem[{prog_buf, arr_col}];
      end
   end

   // ***************************************************************
   // Status flags
   // ***************************************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         status_ready <= 1'b1;
      end else if (launch) begin
         status_ready <= 1'b0;
      end else if (byte_end && col_last) begin
         status_ready <= 1'b1;
      end
   end

   // A failure and a launch never share a cycle, yet the set is tested first so it would win.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         erase_program_fail_flag <= 1'b0;
      end else if (step_done && arr_fail) begin
         erase_program_fail_flag <= 1'b1;
      end else if (launch) begin
         erase_program_fail_flag <= 1'b0;
      end
   end
endmodule

// ---- design/bwp_pkg.sv ----
// Constants and types shared by the buffer write and page program sequencer.
package bwp_pkg;
   // ***************************************************************
   // Opcodes
   // ***************************************************************
   localparam logic [7:0] OPC_LOAD_B1 = 8'h84;
   localparam logic [7:0] OPC_LOAD_B2 = 8'h87;
   localparam logic [7:0] OPC_PROG_ERASE_B1 = 8'h83;
   localparam logic [7:0] OPC_PROG_ERASE_B2 = 8'h86;
   localparam logic [7:0] OPC_PROG_B1 = 8'h88;
   localparam logic [7:0] OPC_PROG_B2 = 8'h89;
   localparam logic [7:0] OPC_LOAD_PROG_B1 = 8'h82;
   localparam logic [7:0] OPC_LOAD_PROG_B2 = 8'h85;

   // ***************************************************************
   // Widths, sizes and field positions
   // ***************************************************************
   localparam int BYTE_W = 8;
   localparam int IDX_W = 10;
   localparam int PAGE_W = 12;
   localparam int MEM_AW = IDX_W + 1;
   localparam int PAGE_LSB_528 = 10;
   localparam int PAGE_LSB_512 = 9;
   localparam int IDX_MSB_512 = 8;
   localparam logic [IDX_W-1:0] BUF_LAST_528 = 10'h20F;
   localparam logic [IDX_W-1:0] BUF_LAST_512 = 10'h1FF;
   localparam logic [1:0] ADDR_LAST = 2'h2;
   localparam logic [1:0] ADDR_DONE = 2'h3;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam int FIFO_W = 9;
   localparam int FIFO_DEPTH = 16;
   localparam int MARK_BIT = 8;

   // ***************************************************************
   // State types
   // ***************************************************************
   typedef enum logic [3:0] {
      DS_OPC = 4'h1,
      DS_ADDR = 4'h2,
      DS_DATA = 4'h4,
      DS_HOLD = 4'h8
   } bwp_dec_t;

   typedef enum logic [4:0] {
      EN_IDLE = 5'h01,
      EN_ERASE = 5'h02,
      EN_EWAIT = 5'h04,
      EN_PROG = 5'h08,
      EN_PWAIT = 5'h10
   } bwp_eng_t;
endpackage

// ---- design/bwp_stream_if.sv ----
// Valid/ready byte stream between the serial front end, the FIFO and the decoder.
interface bwp_stream_if;
   logic valid;
   logic ready;
   logic [8:0] data;
   modport src(output valid, output data, input ready);
   modport snk(input valid, input data, output ready);
endinterface

// ---- design/bwp_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides.
module bwp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic rstn,
   bwp_stream_if.snk wr,
   bwp_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic full;
   logic empty;

   assign empty = (wr_ptr == rd_ptr);
   assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk_sys) begin
      if (wr.valid && !full) begin
         mem[wr_ptr[AW-1:0]] <= wr.data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (wr.valid && !full) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (rd.ready && !empty) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule

// ---- design/bwp_spi_rx.sv ----
// Serial front end: synchronises the pins, shifts bytes and marks frame ends.
module bwp_spi_rx
   import bwp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   bwp_stream_if.src tx,
   output logic overrun
);
   logic sck_s1, sck_s2, sck_d;
   logic cs_s1, cs_s2, cs_d;
   logic si_s1, si_s2;
   logic [2:0] bit_cnt;
   logic [6:0] shreg;
   logic sck_rise;
   logic cs_rise;

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sck_s1 <= 1'b0;
         sck_s2 <= 1'b0;
         sck_d <= 1'b0;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_d <= 1'b1;
         si_s1 <= 1'b0;
         si_s2 <= 1'b0;
      end else begin
         sck_s1 <= spi_sck;
         sck_s2 <= sck_s1;
         sck_d <= sck_s2;
         cs_s1 <= spi_cs_n;
         cs_s2 <= cs_s1;
         cs_d <= cs_s2;
         si_s1 <= spi_si;
         si_s2 <= si_s1;
      end
   end

   assign sck_rise = sck_s2 && !sck_d && !cs_s2;
   assign cs_rise = cs_s2 && !cs_d;

   // ***************************************************************
   // Bit shifter
   // ***************************************************************
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         bit_cnt <= '0;
         shreg <= '0;
      end else if (cs_s2) begin
         bit_cnt <= '0;
      end else if (sck_rise) begin
         shreg <= {shreg[5:0], si_s2};
         bit_cnt <= bit_cnt + 1'b1;
      end
   end

   // ***************************************************************
   // Stream output
   // ***************************************************************
   // The link cannot be stalled, so a byte refused by a full FIFO is lost and flagged.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         tx.valid <= 1'b0;
         tx.data <= '0;
         overrun <= 1'b0;
      end else begin
         if (tx.valid && !tx.ready) begin
            overrun <= 1'b1;
         end
         if (sck_rise && bit_cnt == BIT_LAST) begin
            tx.valid <= 1'b1;
            tx.data <= {1'b0, shreg, si_s2};
         end else if (cs_rise) begin
            tx.valid <= 1'b1;
            tx.data <= {1'b1, 7'h00, bit_cnt == 3'h0};
         end else begin
            tx.valid <= 1'b0;
         end
      end
   end
endmodule

// ---- test/bwp_seq_monitor.sv ----
// Checker for the sequencer array port and status outputs.
module bwp_seq_monitor
   import bwp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_si,
   input wire logic page_528,
   input wire logic arr_done,
   input wire logic arr_fail,
   input wire logic arr_erase,
   input wire logic arr_prog,
   input wire logic [PAGE_W-1:0] arr_page,
   input wire logic [IDX_W-1:0] arr_col,
   input wire logic [BYTE_W-1:0] arr_data,
   input wire logic status_ready,
   input wire logic erase_program_fail_flag,
   input wire logic link_overrun
);
   timeunit 1ns;
   timeprecision 1ns;
   // ********
   // Helpers
   // ********
   // An erase done leaves arr_col at its old value, so it must not look like a byte done.
   logic epend;
   logic [IDX_W-1:0] last;
   assign last = page_528 ? BUF_LAST_528 : BUF_LAST_512;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         epend <= 1'b0;
      end else if (arr_erase) begin
         epend <= 1'b1;
      end else if (arr_done) begin
         epend <= 1'b0;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_req;
      arr_prog || arr_erase;
   endsequence
   sequence s_byte_done;
      arr_done && !epend && !status_ready;
   endsequence
   sequence s_next_col;
      arr_col == $past(arr_col) + 10'h001 ##1 arr_prog;
   endsequence
   // ********
   // Properties
   // ********
   a_erase_busy: assert property (arr_erase |-> !status_ready) else $error("erase while ready");
   a_prog_busy: assert property (arr_prog |-> !status_ready) else $error("program while ready");
   a_req_pulse: assert property (s_req |=> !arr_prog && !arr_erase) else $error("request longer than one cycle");
   a_wait_done: assert property (s_req ##1 !arr_done |=> !arr_prog && !arr_erase) else $error("request before done");
   a_page_stands: assert property (!status_ready && $past(!status_ready) |-> $stable(arr_page)) else $error("page moved");
   a_fail_sets: assert property (arr_done && arr_fail |=> erase_program_fail_flag) else $error("fail flag not set");
   a_flag_clear: assert property ($fell(status_ready) |-> !erase_program_fail_flag) else $error("flag not cleared");
   a_ready_end: assert property (s_byte_done and arr_col == last |=> status_ready) else $error("not ready at end");
   a_busy_mid: assert property (s_byte_done and arr_col != last |=> !status_ready) else $error("ready too early");
   a_col_advance: assert property (s_byte_done and arr_col != last |=> s_next_col) else $error("column stuck");
endmodule

bind bwp_seq bwp_seq_monitor mon (.clk_sys(clk_sys), .rstn(rstn), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
   .spi_si(spi_si), .page_528(page_528), .arr_done(arr_done), .arr_fail(arr_fail), .arr_erase(arr_erase),
   .arr_prog(arr_prog), .arr_page(arr_page), .arr_col(arr_col), .arr_data(arr_data), .status_ready(status_ready),
   .erase_program_fail_flag(erase_program_fail_flag), .link_overrun(link_overrun));

// ---- test/bwp_host_model.sv ----
// Serial host model that sends command frames in mode 0.
module bwp_host_model (
   input wire logic clk_sys,
   output logic spi_sck,
   output logic spi_cs_n,
   output logic spi_si
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_si = 1'b0;
   end
   // Half of the 400 ns serial period.
   task automatic half();
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic shift(input logic b);
      spi_si <= b;
      half();
      spi_sck <= 1'b1;
      half();
      spi_sck <= 1'b0;
   endtask
   task automatic frame(input logic [7:0] q[$], input int extra);
      spi_cs_n <= 1'b0;
      half();
      foreach (q[i]) for (int k = 7; k >= 0; k--) shift(q[i][k]);
      for (int k = 0; k < extra; k++) shift(1'b1);
      half();
      spi_cs_n <= 1'b1;
      // A released line has no pull, so it shows the inverse of the last bit.
      spi_si <= ~spi_si;
      half();
   endtask
endmodule

// ---- test/buffer_write_page_program_bench.sv ----
// Self-checking bench for the buffer write and page program sequencer.
module buffer_write_page_program_bench
   import bwp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic page_528 = 1'b0;
   logic arr_done = 1'b0;
   logic arr_fail = 1'b0;
   logic arr_erase, arr_prog, status_ready, erase_program_fail_flag, link_overrun;
   logic spi_sck, spi_cs_n, spi_si;
   logic [PAGE_W-1:0] arr_page;
   logic [IDX_W-1:0] arr_col;
   logic [BYTE_W-1:0] arr_data;
   int seed = 37191;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;
   int fail_col = -1;
   int dly = 0;
   logic erase_fail = 1'b0;
   logic exp_flag, pend_erase;
   logic pend = 1'b0;
   logic [31:0] notes[$];
   logic [31:0] n, seen, mask;
   logic [7:0] bmem[2][528];
   logic known[2][528];

   bwp_seq dut (.clk_sys(clk_sys), .rstn(rstn), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
      .page_528(page_528), .arr_done(arr_done), .arr_fail(arr_fail), .arr_erase(arr_erase), .arr_prog(arr_prog),
      .arr_page(arr_page), .arr_col(arr_col), .arr_data(arr_data), .status_ready(status_ready),
      .erase_program_fail_flag(erase_program_fail_flag), .link_overrun(link_overrun));
   bwp_host_model host (.clk_sys(clk_sys), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si));

   initial begin
      forever #25 clk_sys = ~clk_sys;
   end
   // ********
   // Array model with random answer delay
   // ********
   always @(posedge clk_sys) begin
      arr_done <= 1'b0;
      arr_fail <= 1'b0;
      if (arr_erase || arr_prog) begin
         pend <= 1'b1;
         pend_erase <= arr_erase;
         dly <= $random(seed) & 3;
      end else if (pend && dly > 0) begin
         dly <= dly - 1;
      end else if (pend) begin
         pend <= 1'b0;
         arr_done <= 1'b1;
         arr_fail <= pend_erase ? erase_fail : (int'(arr_col) == fail_col);
      end
   end
   // ********
   // Result checker and timeout
   // ********
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 80000) begin
         fails++;
         $display("BAD run length expected end seen timeout");
         end_sim();
      end
      if (rstn && (arr_erase || arr_prog)) begin
         check_count++;
         seen = {1'b0, arr_erase, arr_page, arr_col, arr_data};
         if (notes.size() == 0) begin
            fails++;
            $display("BAD array request expected none seen %h", seen);
         end else begin
            n = notes.pop_front();
            mask = n[30] ? 32'h7FFC0000 : (n[31] ? 32'h7FFFFF00 : 32'h7FFFFFFF);
            if ((seen & mask) !== (n & mask)) begin
               fails++;
               $display("BAD array request expected %h seen %h", n & mask, seen & mask);
            end
         end
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_ready(input logic lvl, input int lim);
      int i;
      i = 0;
      while (status_ready !== lvl && i < lim) begin
         @(posedge clk_sys);
         i++;
      end
      chk("status_ready", lvl, status_ready);
   endtask
   task automatic cmd(input logic [7:0] opc, input logic [11:0] page, input logic [9:0] idx, input int nd,
      input int b, input bit er, input bit pr, input int extra);
      logic [7:0] q[$];
      logic [23:0] a;
      int last;
      int c;
      last = page_528 ? 527 : 511;
      a = page_528 ? {2'b00, page, idx} : {3'b000, page, idx[8:0]};
      q = {opc, a[23:16], a[15:8], a[7:0]};
      c = page_528 ? idx : idx[8:0];
      for (int i = 0; i < nd; i++) begin
         q.push_back(8'($random(seed)));
         bmem[b][c] = q[q.size()-1];
         known[b][c] = 1'b1;
         c = (c == last) ? 0 : c + 1;
      end
      if (pr) begin
         if (er) notes.push_back({2'b01, page, 18'h0});
         for (int k = 0; k <= last; k++) notes.push_back({!known[b][k], 1'b0, page, k[9:0], bmem[b][k]});
         exp_flag = (er && erase_fail) || fail_col >= 0;
      end
      host.frame(q, extra);
      if (pr) begin
         wait_ready(1'b0, 40);
         wait_ready(1'b1, 20000);
         chk("fail flag", exp_flag, erase_program_fail_flag);
      end
      $display("test opcode %h done", opc);
   endtask
   task automatic end_sim();
      $display("counts: %0d checks, %0d fails", check_count, fails);
      if (fails == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      foreach (known[i, j]) known[i][j] = 1'b0;
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      cmd(OPC_LOAD_B1, 12'h000, 10'h1FE, 512, 0, 0, 0, 0);
      fail_col = 5;
      cmd(OPC_PROG_ERASE_B1, 12'hA5C, 10'h000, 0, 0, 1, 1, 0);
      fail_col = -1;
      // The array model holds no contents, so every target page counts as erased.
      cmd(OPC_PROG_B1, 12'h3C1, 10'h000, 0, 0, 0, 1, 0);
      host.frame('{OPC_PROG_ERASE_B2, 8'h12, 8'h34}, 0);
      cmd(OPC_PROG_ERASE_B1, 12'h111, 10'h000, 0, 0, 1, 0, 3);
      repeat (100) @(posedge clk_sys);
      chk("status_ready", 1'b1, status_ready);
      page_528 <= 1'b1;
      repeat (4) @(posedge clk_sys);
      erase_fail = 1'b1;
      cmd(OPC_LOAD_PROG_B1, 12'h7FF, 10'h20E, 4, 0, 1, 1, 0);
      erase_fail = 1'b0;
      cmd(OPC_LOAD_B2, 12'h000, 10'h003, 3, 1, 0, 0, 0);
      cmd(OPC_PROG_ERASE_B2, 12'h001, 10'h000, 0, 1, 1, 1, 0);
      cmd(OPC_PROG_B2, 12'h800, 10'h000, 0, 1, 0, 1, 0);
      cmd(OPC_LOAD_PROG_B2, 12'h456, 10'h100, 2, 1, 1, 1, 0);
      chk("link_overrun", 32'h0, link_overrun);
      chk("notes left", 32'h0, notes.size());
      end_sim();
   end
endmodule
